// ===== rtl/sctl_top.sv
// Serial port control register logic behind an AHB-Lite slave
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "sctl_consts.svh"

// Operation
// R1: Control register readable, writable, cleared reset/standby
// R2: Bit 7 gates transmit-empty request
// R3: Read-one-then-clear or disable withdraws transmit-empty
// R4: Bit 6 gates receive-full and receive-error
// R5: Read-one-then-clear or disable withdraws receive requests
// R6: Transmit off holds empty flag at one
// R7: Transmit starts after data write, flag clear
// R8: Software sets format before enabling transfers
// R9: Receive disable keeps receive flags unchanged
// R10: Receive starts on start bit or clock; rx_active is rx_on alone in async and waits for rx_start_seen in sync
// R11: Address wait valid only async multiprocessor
// R12: Address wait skips non-address characters entirely
// R13: Address character sets flag, ends wait
// R14: Bit 2 gates transmit-done request
// R15: Bits 1,0 select clock source, output
// R16: Clock output honoured only async internal
// R17: Format bit 2 selects multiprocessor, async only
// R18: Each request is enable AND flag
module sctl_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic standby,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic hready,
    input wire sctl_pkg::sctl_rx_char_t rx_char,
    input wire logic rx_start_seen,
    input wire logic tx_shift_idle,
    input wire logic tx_msb_sending,
    output logic tx_load,
    output logic [7:0] tx_shift_data,
    output logic rx_active,
    output var sctl_pkg::sctl_sck_t sck,
    output logic tx_empty_irq,
    output logic rx_full_irq,
    output logic rx_fault_irq,
    output logic tx_done_irq,
    output logic irq
);
    sctl_pkg::sctl_state_t st;
    sctl_pkg::sctl_state_t next_st;
    logic async_mp;
    logic wait_active;
    logic wr_now;
    logic [7:0] wbyte;
    logic [3:0] events;
    logic rx_take;
    logic rx_addr_char;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    // Multiprocessor format only counts in asynchronous mode
    assign async_mp = !st.format[`SCTL_FMT_SYNC] && st.format[`SCTL_FMT_MP]; // see R17
    assign wait_active = st.ctrl.address_wait_enable && async_mp; // see R11
    assign wr_now = (st.phase == sctl_pkg::SCTL_DATA) && st.wr;
    assign wbyte = hwdata[7:0];
    // A character is taken only when receiving and not skipped
    assign rx_addr_char = rx_char.valid && st.ctrl.rx_on && async_mp && rx_char.frame_address;
    assign rx_take = rx_char.valid && st.ctrl.rx_on && (!wait_active || rx_char.frame_address); // see R12

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Bus decode, register writes and flag updates
    always_comb begin
        next_st = st;
        next_st.tx_start = 1'b0;
        events = 4'h0;
        if (hready) begin
            if (hsel && htrans[1]) begin
                next_st.phase = sctl_pkg::SCTL_DATA;
                next_st.addr = haddr[7:0];
                next_st.wr = hwrite;
            end else begin
                next_st.phase = sctl_pkg::SCTL_IDLE;
            end
        end
        // Read data latched at the end of the address phase of a read
        next_st.rdata = 32'h0000_0000;
        if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                `SCTL_OFF_CONTROL: next_st.rdata = {24'h000000, st.ctrl}; // see R1
                `SCTL_OFF_STATUS: next_st.rdata = {24'h000000, st.status};
                `SCTL_OFF_FORMAT: next_st.rdata = {24'h000000, st.format};
                `SCTL_OFF_TXDATA: next_st.rdata = {24'h000000, st.tx_data};
                `SCTL_OFF_RXDATA: next_st.rdata = {24'h000000, st.rx_data};
                `SCTL_OFF_IRQ_STAT: next_st.rdata = {28'h0000000, st.irq_stat};
                `SCTL_OFF_IRQ_MASK: next_st.rdata = {28'h0000000, st.irq_mask};
                default: next_st.rdata = 32'h0000_0000;
            endcase
            // Reading the status arms the clear of each flag in bits 7 to 3 seen at one
            if (haddr[7:0] == `SCTL_OFF_STATUS) begin
                next_st.seen_set = st.status & `SCTL_CLEARABLE; // see R3, R5
            end
        end
        // Register writes
        if (wr_now) begin
            case (st.addr)
                `SCTL_OFF_CONTROL: next_st.ctrl = wbyte; // see R1
                `SCTL_OFF_FORMAT: next_st.format = wbyte;
                `SCTL_OFF_TXDATA: next_st.tx_data = wbyte;
                `SCTL_OFF_STATUS: begin
                    // Zero written clears a flag only if it was read as one
                    next_st.status = st.status & ~(st.seen_set & ~wbyte); // see R3, R5
                    next_st.seen_set = st.seen_set & wbyte;
                    if (st.seen_set[`SCTL_ST_TX_BUFFER_EMPTY_FLAG] && !wbyte[`SCTL_ST_TX_BUFFER_EMPTY_FLAG] && st.ctrl.tx_on) begin
                        next_st.tx_start = 1'b1; // see R7
                    end
                end
                `SCTL_OFF_IRQ_STAT: next_st.irq_stat = st.irq_stat & ~wbyte[3:0];
                `SCTL_OFF_IRQ_MASK: next_st.irq_mask = wbyte[3:0];
                default: next_st.ctrl = next_st.ctrl;
            endcase
        end
        // Transmit path: the empty flag sets again when the shifter is idle; tx_load does not wait for the shifter
        if (st.ctrl.tx_on && !st.status[`SCTL_ST_TX_BUFFER_EMPTY_FLAG] && tx_shift_idle && !next_st.tx_start) begin
            next_st.status[`SCTL_ST_TX_BUFFER_EMPTY_FLAG] = 1'b1; // see R2
            next_st.status[`SCTL_ST_TEND] = 1'b0;
            events[0] = 1'b1;
        end
        if (tx_msb_sending && st.status[`SCTL_ST_TX_BUFFER_EMPTY_FLAG]) begin
            next_st.status[`SCTL_ST_TEND] = 1'b1; // see R14
            events[3] = 1'b1;
        end
        // Receive path; rx_on low leaves every receive flag alone
        if (rx_take) begin // see R9, R12
            if (st.status[`SCTL_ST_RX_BUFFER_FULL_FLAG]) begin
                next_st.status[`SCTL_ST_OVERRUN_FLAG] = 1'b1;
                events[2] = 1'b1;
            end else begin
                next_st.rx_data = rx_char.data;
                next_st.status[`SCTL_ST_RX_BUFFER_FULL_FLAG] = 1'b1; // see R4
                next_st.status[`SCTL_ST_FER] = rx_char.framing_fault;
                next_st.status[`SCTL_ST_PER] = rx_char.parity_fault && !async_mp;
                events[1] = 1'b1;
                events[2] = rx_char.framing_fault || (rx_char.parity_fault && !async_mp);
            end
        end
        if (rx_addr_char) begin
            next_st.status[`SCTL_ST_MPB] = 1'b1; // see R13
            next_st.ctrl.address_wait_enable = 1'b0; // see R13
        end else if (rx_take && async_mp) begin
            next_st.status[`SCTL_ST_MPB] = 1'b0;
        end
        // Transmit off pins the empty flag high
        if (!next_st.ctrl.tx_on) begin
            next_st.status[`SCTL_ST_TX_BUFFER_EMPTY_FLAG] = 1'b1; // see R6
        end
        // Sticky event bits; a set beats a same-cycle clear
        next_st.irq_stat = next_st.irq_stat | events;
        // Standby clears the registers like reset, but not the event bits or their mask
        if (standby) begin
            next_st.ctrl = `SCTL_CTRL_RESET; // see R1
            next_st.status = `SCTL_STAT_RESET;
            next_st.format = `SCTL_FMT_RESET;
            next_st.tx_data = `SCTL_TXD_RESET;
            next_st.rx_data = 8'h00;
            next_st.seen_set = 8'h00;
            next_st.tx_start = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Whole state, frozen while clk_en is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '{phase: sctl_pkg::SCTL_IDLE, addr: 8'h00, wr: 1'b0, ctrl: `SCTL_CTRL_RESET,
                    format: `SCTL_FMT_RESET, status: `SCTL_STAT_RESET, seen_set: 8'h00,
                    tx_data: `SCTL_TXD_RESET, rx_data: 8'h00, irq_stat: 4'h0, irq_mask: 4'h0,
                    tx_start: 1'b0, rdata: 32'h0000_0000};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Bus answers with no wait state
    assign hrdata = st.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // Transmit and receive gating
    assign tx_load = st.tx_start; // see R7
    assign tx_shift_data = st.tx_data;
    assign rx_active = st.ctrl.rx_on && (rx_start_seen || !st.format[`SCTL_FMT_SYNC]); // see R10
    // Clock pin: out in sync internal, or async internal with output on
    assign sck.internal_clock = !st.ctrl.clock_source_select; // see R15
    assign sck.out = !st.ctrl.clock_source_select &&
                     (st.format[`SCTL_FMT_SYNC] || st.ctrl.clock_output_enable); // see R16
    assign sck.oe = sck.out;
    // Requests are enable AND flag
    assign tx_empty_irq = st.ctrl.tx_irq_enable && st.status[`SCTL_ST_TX_BUFFER_EMPTY_FLAG]; // see R18, R2
    assign rx_full_irq = st.ctrl.rx_irq_enable && st.status[`SCTL_ST_RX_BUFFER_FULL_FLAG]; // see R18, R4
    assign rx_fault_irq = st.ctrl.rx_irq_enable &&
                          (|st.status[`SCTL_ST_OVERRUN_FLAG:`SCTL_ST_PER]); // see R18, R4
    assign tx_done_irq = st.ctrl.tx_done_irq_enable && st.status[`SCTL_ST_TEND]; // see R18, R14
    assign irq = |(st.irq_stat & st.irq_mask);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_addr_char;
        rx_addr_char && clk_en && !standby;
    endsequence
    sequence s_wait_cleared;
        !st.ctrl.address_wait_enable && st.status[`SCTL_ST_MPB];
    endsequence

    a_ctrl_reset_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (standby && clk_en) |=> (st.ctrl == 8'h00)) else $error("control not cleared in standby"); // see R1
    a_tx_empty_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_empty_irq == (st.ctrl.tx_irq_enable && st.status[7])) else $error("tx empty request wrong"); // see R2
    a_tx_off_empty: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.ctrl.tx_on |-> st.status[7]) else $error("empty flag low while tx off"); // see R6
    a_tx_start_cause: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_load |-> $past(st.ctrl.tx_on) && !st.status[7]) else $error("tx load without clear"); // see R7
    a_rx_off_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st.ctrl.rx_on && !wr_now && !standby && clk_en) |=> $stable(st.status[6:3]))
        else $error("rx flags moved while rx off"); // see R9
    a_skip_char: assert property (@(posedge hclk) disable iff (!hresetn)
        (wait_active && rx_char.valid && !rx_char.frame_address && !st.status[6] && clk_en && !standby && !wr_now)
        |=> !st.status[6]) else $error("skipped char set full flag"); // see R12
    a_addr_resume: assert property (@(posedge hclk) disable iff (!hresetn)
        s_addr_char |=> s_wait_cleared) else $error("address char did not end wait"); // see R13
    a_rx_fault_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.ctrl.rx_irq_enable |-> !rx_full_irq && !rx_fault_irq) else $error("rx request while disabled"); // see R5
    a_sck_drive: assert property (@(posedge hclk) disable iff (!hresetn)
        st.ctrl.clock_source_select |-> !sck.oe) else $error("clock driven with external source"); // see R16
endmodule : sctl_top
`default_nettype wire

// ===== rtl/sctl_consts.svh
// Offsets, field positions and reset values of the serial port control block
`ifndef SCTL_CONSTS_SVH
`define SCTL_CONSTS_SVH
`define SCTL_OFF_CONTROL 8'h00
`define SCTL_OFF_STATUS 8'h04
`define SCTL_OFF_FORMAT 8'h08
`define SCTL_OFF_TXDATA 8'h0C
`define SCTL_OFF_RXDATA 8'h10
`define SCTL_OFF_IRQ_STAT 8'h14
`define SCTL_OFF_IRQ_MASK 8'h18
`define SCTL_CTRL_RESET 8'h00
`define SCTL_STAT_RESET 8'h84
`define SCTL_FMT_RESET 8'h00
`define SCTL_TXD_RESET 8'hFF
`define SCTL_ST_TX_BUFFER_EMPTY_FLAG 7
`define SCTL_ST_RX_BUFFER_FULL_FLAG 6
`define SCTL_ST_OVERRUN_FLAG 5
`define SCTL_ST_FER 4
`define SCTL_ST_PER 3
`define SCTL_ST_TEND 2
`define SCTL_ST_MPB 1
`define SCTL_FMT_SYNC 7
`define SCTL_FMT_MP 2
`define SCTL_CLEARABLE 8'hF8
`endif

// ===== rtl/sctl_pkg.sv
// Types of the serial port control block
package sctl_pkg;
    // Control register layout, bit 7 down to 0
    typedef struct packed {
        logic tx_irq_enable;
        logic rx_irq_enable;
        logic tx_on;
        logic rx_on;
        logic address_wait_enable;
        logic tx_done_irq_enable;
        logic clock_source_select;
        logic clock_output_enable;
    } sctl_ctrl_t;

    // Character delivered by the receive framer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic frame_address;
        logic framing_fault;
        logic parity_fault;
    } sctl_rx_char_t;

    // Serial clock pin drive
    typedef struct packed {
        logic out;
        logic oe;
        logic internal_clock;
    } sctl_sck_t;

    typedef enum logic [1:0] {
        SCTL_IDLE = 2'b00,
        SCTL_DATA = 2'b01
    } sctl_phase_t;

    // Whole state of the block
    typedef struct packed {
        sctl_phase_t phase;
        logic [7:0] addr;
        logic wr;
        sctl_ctrl_t ctrl;
        logic [7:0] format;
        logic [7:0] status;
        logic [7:0] seen_set;
        logic [7:0] tx_data;
        logic [7:0] rx_data;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic tx_start;
        logic [31:0] rdata;
    } sctl_state_t;
endpackage : sctl_pkg

// ===== tb/sctl_far_end.sv
// Far side model: transmit shifter and receive framer
`timescale 1ns/100ps
`default_nettype none
module sctl_far_end (
    input wire logic hclk,
    input wire logic tx_load,
    input wire logic [7:0] tx_shift_data,
    output var sctl_pkg::sctl_rx_char_t rx_char,
    output var logic rx_start_seen,
    output logic tx_shift_idle,
    output logic tx_msb_sending
);
    logic [3:0] bits_left = 4'h0;
    logic [7:0] last_tx = 8'h00;
    // Shifter takes a character and spends eight bit times on it
    always @(posedge hclk) begin
        if (tx_load) begin
            last_tx <= tx_shift_data;
            bits_left <= 4'h8;
        end else if (bits_left != 4'h0) begin
            bits_left <= bits_left - 4'h1;
        end
    end
    assign tx_shift_idle = (bits_left == 4'h0);
    assign tx_msb_sending = (bits_left == 4'h1); // Last bit time carries the top bit
    // Framer hands over one character two cycles after a start bit
    task automatic send_char(input logic [7:0] d, input logic adr, input logic ff);
        @(posedge hclk);
        rx_start_seen <= 1'b1;
        repeat (2) @(posedge hclk);
        rx_char <= {1'b1, d, adr, ff, 1'b0};
        @(posedge hclk);
        rx_char <= {1'b0, ~d, ~adr, 2'b00}; // Stale data and address bit inverted, fault bits zeroed once invalid
        rx_start_seen <= 1'b0;
    endtask : send_char
    // Quiet line at time zero
    initial begin
        rx_char = '0;
        rx_start_seen = 1'b0;
    end
endmodule : sctl_far_end
`default_nettype wire

// ===== tb/tb_sctl_top.sv
// Self-checking bench for the serial control register logic
`timescale 1ns/100ps
`default_nettype none
`include "sctl_consts.svh"
module tb_sctl_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic clk_en = 1'b1;
    logic standby = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, tx_load, rx_active, rx_start_seen, tx_shift_idle, tx_msb_sending;
    logic tx_empty_irq, rx_full_irq, rx_fault_irq, tx_done_irq, irq;
    logic [7:0] tx_shift_data;
    sctl_pkg::sctl_rx_char_t rx_char;
    sctl_pkg::sctl_sck_t sck;
    logic [31:0] rd;
    int n;
    int failures = 0;
    int checks_done = 0;

    sctl_top dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .standby(standby), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .hready(hreadyout), .rx_char(rx_char),
        .rx_start_seen(rx_start_seen), .tx_shift_idle(tx_shift_idle), .tx_msb_sending(tx_msb_sending),
        .tx_load(tx_load), .tx_shift_data(tx_shift_data), .rx_active(rx_active), .sck(sck),
        .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq), .rx_fault_irq(rx_fault_irq),
        .tx_done_irq(tx_done_irq), .irq(irq));
    sctl_far_end far (.hclk(hclk), .tx_load(tx_load), .tx_shift_data(tx_shift_data), .rx_char(rx_char),
        .rx_start_seen(rx_start_seen), .tx_shift_idle(tx_shift_idle), .tx_msb_sending(tx_msb_sending));

    // ----------------------------------------
    // Bus cycles and comparisons
    // ----------------------------------------
    // One AHB single transfer, entered just after a rising edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        #1; // Let this edge's updates land
    endtask : ahb
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(what, e, rd & m);
    endtask : rdchk
    task automatic conclude();
        $display("Checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // ----------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------
    initial begin
        forever #2 hclk = ~hclk;
    end
    // Cuts a hang short
    initial begin
        #100000;
        failures++;
        conclude();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk("control reset", `SCTL_OFF_CONTROL, 32'hFFFFFFFF, 32'h0);
        rdchk("status reset", `SCTL_OFF_STATUS, 32'hFFFFFFFF, 32'h84);
        rdchk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
        chk("bus response okay", 32'h0, {31'h0, hresp});
        wr(`SCTL_OFF_CONTROL, 32'hC3);
        rdchk("control rw", `SCTL_OFF_CONTROL, 32'hFFFFFFFF, 32'hC3);
        chk("sck ext", 32'h0, {30'h0, sck.oe, sck.internal_clock});
        wr(`SCTL_OFF_CONTROL, 32'h81);
        chk("sck int out", 32'h3, {30'h0, sck.oe, sck.internal_clock});
        chk("tx empty irq off tx", 32'h1, {31'h0, tx_empty_irq});
        wr(`SCTL_OFF_CONTROL, 32'h0);
        chk("tx empty irq disabled", 32'h0, {31'h0, tx_empty_irq});
        $display("Test registers done");
        wr(`SCTL_OFF_FORMAT, 32'h0);
        wr(`SCTL_OFF_TXDATA, 32'h5A);
        wr(`SCTL_OFF_CONTROL, 32'hA4);
        rdchk("tx empty seen", `SCTL_OFF_STATUS, 32'h80, 32'h80);
        wr(`SCTL_OFF_STATUS, 32'h0);
        n = 0;
        while (!(tx_shift_idle === 1'b1 && far.last_tx === 8'h5A && tx_done_irq === 1'b1) && n < 100) begin
            @(posedge hclk);
            n++;
        end
        #1;
        chk("shifted data", 32'h5A, {24'h0, far.last_tx});
        chk("tx done irq", 32'h1, {31'h0, tx_done_irq});
        chk("tx empty irq", 32'h1, {31'h0, tx_empty_irq});
        rdchk("irq stat tx", `SCTL_OFF_IRQ_STAT, 32'h1, 32'h1);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`SCTL_OFF_IRQ_MASK, 32'h1);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(`SCTL_OFF_IRQ_STAT, 32'h1);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("Test transmit done");
        wr(`SCTL_OFF_CONTROL, 32'h50);
        chk("rx active async", 32'h1, {31'h0, rx_active});
        far.send_char(8'h3C, 1'b0, 1'b0);
        rdchk("rx full", `SCTL_OFF_STATUS, 32'h40, 32'h40);
        chk("rx full irq", 32'h1, {31'h0, rx_full_irq});
        rdchk("rx data", `SCTL_OFF_RXDATA, 32'hFF, 32'h3C);
        wr(`SCTL_OFF_CONTROL, 32'h40);
        chk("rx inactive when off", 32'h0, {31'h0, rx_active});
        rdchk("rx flag kept", `SCTL_OFF_STATUS, 32'h40, 32'h40);
        wr(`SCTL_OFF_STATUS, 32'h0);
        chk("rx irq withdrawn", 32'h0, {31'h0, rx_full_irq});
        wr(`SCTL_OFF_CONTROL, 32'h50);
        far.send_char(8'h99, 1'b0, 1'b1);
        rdchk("framing", `SCTL_OFF_STATUS, 32'h10, 32'h10);
        chk("rx fault irq", 32'h1, {31'h0, rx_fault_irq});
        wr(`SCTL_OFF_CONTROL, 32'h10);
        chk("rx fault disabled", 32'h0, {31'h0, rx_fault_irq});
        wr(`SCTL_OFF_STATUS, 32'h0);
        $display("Test receive done");
        wr(`SCTL_OFF_FORMAT, 32'h04);
        wr(`SCTL_OFF_CONTROL, 32'h58);
        far.send_char(8'h11, 1'b0, 1'b1);
        rdchk("skipped data", `SCTL_OFF_STATUS, 32'h50, 32'h0);
        chk("skip no irq", 32'h0, {30'h0, rx_full_irq, rx_fault_irq});
        far.send_char(8'h22, 1'b1, 1'b0);
        rdchk("address frame", `SCTL_OFF_STATUS, 32'h42, 32'h42);
        rdchk("wait ended", `SCTL_OFF_CONTROL, 32'hFF, 32'h50);
        rdchk("address data", `SCTL_OFF_RXDATA, 32'hFF, 32'h22);
        $display("Test address wait done");
        standby <= 1'b1;
        repeat (2) @(posedge hclk);
        standby <= 1'b0;
        rdchk("standby control", `SCTL_OFF_CONTROL, 32'hFFFFFFFF, 32'h0);
        rdchk("standby status", `SCTL_OFF_STATUS, 32'hFFFFFFFF, 32'h84);
        $display("Test standby done");
        conclude();
    end
endmodule : tb_sctl_top
`default_nettype wire
